// File: hdl/dcfg_consts.svh
// Summary of operation
// - power-mode bit 5 set: power-down pin gives full power-down, clear gives standby.
// - internal power mode 00: both channels run normally.
// - mode 01: datapath clock stopped, datapath reset, outputs disabled.
// - mode 10 standby: datapath clock stopped, outputs disabled.
// - mode 11: clock stopped, datapath held in reset, outputs stay enabled.
// - enhancement bit 2 enables first-stage chopping.
// - LVDS interleaved: channel A during clock high, channel B during clock low.
// - LVDS plain: A low bits, B high bits; even bits high, odd bits low.
// - CMOS interleaved: port A gives A low, B high; port B the reverse.
// - CMOS plain: single rate, A on port A, B on port B.
// - output mode bit 4 disables ports of channels selected in channel index; LVDS port A goes off only once both are disabled.
// - output mode bit 2 inverts data of channels selected in channel index.
// - format bits 1:0: offset binary 00, twos complement 01, Gray 10.
// - sync bit 1 gates sync pulses to divider, every pulse resyncs.
// - with sync bit 2, only first pulse syncs, then sync enable clears.
// - writes act at once except override, which loads on transfer bit 0.
// - override may only downgrade; an upgrade forces chip power-down.
// - user I/O 2 bit 7 enables the output-enable pin; clear ignores it.
// - user I/O 3 bit 3 powers down the common-mode generator.
// - output driver type defaults to CMOS after power-up.
// - override resolution 010/100/110 = 14/12/10 bits; rate 011/100/101.
`ifndef DCFG_CONSTS_SVH
`define DCFG_CONSTS_SVH
`define DCFG_A_CHAN_IDX   13'h005
`define DCFG_A_PWR        13'h008
`define DCFG_A_ENH        13'h00c
`define DCFG_A_OUTM       13'h014
`define DCFG_A_SYNC       13'h03a
`define DCFG_A_XFER       13'h0ff
`define DCFG_A_OVR        13'h100
`define DCFG_A_UIO2       13'h101
`define DCFG_A_UIO3       13'h102
`define DCFG_M_CHAN_IDX   8'h03
`define DCFG_M_PWR        8'h23
`define DCFG_M_ENH        8'h04
`define DCFG_M_OUTM       8'he3
`define DCFG_M_SYNC       8'h06
`define DCFG_M_OVR        8'h7f
`define DCFG_M_UIO2       8'h81
`define DCFG_M_UIO3       8'h08
`define DCFG_R_CHAN_IDX   8'h03
`define DCFG_R_ZERO       8'h00
`define DCFG_B_PIN_FULL   5
`define DCFG_B_CHOP       2
`define DCFG_B_LVDS       7
`define DCFG_B_LVDS_RED   6
`define DCFG_B_ILV        5
`define DCFG_B_PORT_DIS   4
`define DCFG_B_INV        2
`define DCFG_B_SYNC_NEXT  2
`define DCFG_B_SYNC_EN    1
`define DCFG_B_XFER       0
`define DCFG_B_OVR_EN     6
`define DCFG_B_OEB_EN     7
`define DCFG_B_PULL_DIS   0
`define DCFG_B_CM_PD      3
`define DCFG_RES_14       3'h2
`define DCFG_RES_12       3'h4
`define DCFG_RES_10       3'h6
`define DCFG_RATE_80      3'h3
`define DCFG_RATE_105     3'h4
`define DCFG_RATE_125     3'h5
`define DCFG_RATE_DEFAULT 3'h5
`define DCFG_SPI_INSTR    5'd16
`define DCFG_SPI_LAST     5'd23
`define DCFG_SPI_END      5'd24
`define DCFG_MASK_12      14'h3ffc
`define DCFG_MASK_10      14'h3ff0
`define DCFG_MASK_14      14'h3fff
`endif

// File: hdl/dcfg_pkg.sv
package dcfg_pkg;
    typedef struct packed {
        logic [13:0] a;
        logic [13:0] b;
    } dcfg_pair_t;
    typedef struct packed {
        logic       en;
        logic [2:0] res;
        logic [2:0] rate;
    } dcfg_ovr_t;
    typedef enum logic [1:0] {
        PS_RUN,
        PS_STBY,
        PS_DOWN,
        PS_DRST
    } dcfg_pwr_t;
endpackage

// File: hdl/dcfg_top.sv
`include "dcfg_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module dcfg_top
    import dcfg_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        sys_rst_i,
    input  wire logic        ce_i,
    input  wire logic        spi_csb_n_i,
    input  wire logic        spi_sclk_i,
    input  wire logic        spi_sdio_i,
    output var  logic        spi_sdio_o,
    output var  logic        spi_sdio_oe_n_o,
    input  wire logic        power_down_pin_i,
    input  wire logic        output_enable_pin_n_i,
    input  wire logic        sync_i,
    input  wire logic [13:0] adc_a_i,
    input  wire logic [13:0] adc_b_i,
    output var  logic [13:0] port_a_o,
    output var  logic [13:0] port_b_o,
    output var  logic        data_clock_out_o,
    output var  logic        port_a_en_o,
    output var  logic        port_b_en_o,
    output var  logic        lvds_en_o,
    output var  logic        lvds_reduced_o,
    output var  logic        chop_en_o,
    output var  logic        common_mode_voltage_pd_o,
    output var  logic        sdio_pull_dis_o,
    output var  logic        divider_resync_o,
    output var  logic        full_power_down_o,
    output var  logic        standby_o,
    output var  logic [6:0]  ovr_active_o
);
    logic [7:0]  chan_idx;
    logic [7:0]  pwr_mode;
    logic [7:0]  enh;
    logic [7:0]  out_mode;
    logic [1:0]  port_dis;
    logic [1:0]  port_inv;
    logic [7:0]  sync_ctl;
    logic [7:0]  ovr_stage;
    logic [7:0]  uio2;
    logic [7:0]  uio3;
    dcfg_ovr_t   ovr_act;
    dcfg_pwr_t   pwr_state;
    dcfg_pwr_t   next_pwr_state;
    dcfg_pair_t  cap;
    logic        phase;
    logic        sclk_q;
    logic [4:0]  bit_cnt;
    logic [15:0] instr;
    logic [6:0]  wshift;

    function automatic logic [13:0] fmt(input logic [13:0] s, input logic [1:0] f);
        case (f)
            2'h1:    fmt = {~s[13], s[12:0]};
            2'h2:    fmt = s ^ {1'b0, s[13:1]};
            default: fmt = s;
        endcase
    endfunction

    function automatic logic [13:0] res_mask(input dcfg_ovr_t o);
        if (!o.en) begin
            res_mask = `DCFG_MASK_14;
        end else if (o.res == `DCFG_RES_12) begin
            res_mask = `DCFG_MASK_12;
        end else if (o.res == `DCFG_RES_10) begin
            res_mask = `DCFG_MASK_10;
        end else begin
            res_mask = `DCFG_MASK_14;
        end
    endfunction

    function automatic logic [13:0] pick(input logic [27:0] w, input logic odd);
        logic [13:0] r;
        r = 14'h0;
        for (int i = 0; i < 14; i++) begin
            r[i] = odd ? w[2*i+1] : w[2*i];
        end
        pick = r;
    endfunction

    // serial port, sampled on the system clock
    wire        sclk_rise = spi_sclk_i & ~sclk_q & ~spi_csb_n_i;
    wire        sclk_fall = ~spi_sclk_i & sclk_q & ~spi_csb_n_i;
    wire        is_read   = instr[15];
    wire [12:0] addr      = instr[12:0];
    wire        in_data   = (bit_cnt >= `DCFG_SPI_INSTR) && (bit_cnt <= `DCFG_SPI_LAST);
    wire        wr_fire   = sclk_rise && (bit_cnt == `DCFG_SPI_LAST) && !is_read;
    wire [7:0]  wr_data   = {wshift, spi_sdio_i};
    wire        wr_pwr    = wr_fire && (addr == `DCFG_A_PWR);
    wire        wr_enh    = wr_fire && (addr == `DCFG_A_ENH);
    wire        wr_outm   = wr_fire && (addr == `DCFG_A_OUTM);
    wire        wr_chan   = wr_fire && (addr == `DCFG_A_CHAN_IDX);
    wire        wr_sync   = wr_fire && (addr == `DCFG_A_SYNC);
    wire        wr_xfer   = wr_fire && (addr == `DCFG_A_XFER);
    wire        wr_ovr    = wr_fire && (addr == `DCFG_A_OVR);
    wire        wr_uio2   = wr_fire && (addr == `DCFG_A_UIO2);
    wire        wr_uio3   = wr_fire && (addr == `DCFG_A_UIO3);
    // per-channel fields read back for channel a when it is selected
    wire        rd_sel_b  = !chan_idx[0] && chan_idx[1];
    wire [7:0]  outm_rd   = out_mode
                          | {3'h0, port_dis[rd_sel_b], 1'b0, port_inv[rd_sel_b], 2'h0};
    wire [7:0]  rd_val    = (addr == `DCFG_A_CHAN_IDX) ? chan_idx :
                            (addr == `DCFG_A_PWR)      ? pwr_mode :
                            (addr == `DCFG_A_ENH)      ? enh :
                            (addr == `DCFG_A_OUTM)     ? outm_rd :
                            (addr == `DCFG_A_SYNC)     ? sync_ctl :
                            (addr == `DCFG_A_OVR)      ? ovr_stage :
                            (addr == `DCFG_A_UIO2)     ? uio2 :
                            (addr == `DCFG_A_UIO3)     ? uio3 : `DCFG_R_ZERO;

    // edge detect wants the serial clock held at least one system clock per half
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sclk_q <= 1'b0;
        end else if (ce_i) begin
            sclk_q <= spi_sclk_i;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bit_cnt <= 5'd0;
            instr   <= 16'h0;
            wshift  <= 7'h0;
        end else if (ce_i) begin
            if (spi_csb_n_i) begin
                bit_cnt <= 5'd0;
            end else if (sclk_rise && bit_cnt != `DCFG_SPI_END) begin
                bit_cnt <= bit_cnt + 5'd1;
                if (bit_cnt < `DCFG_SPI_INSTR) begin
                    instr <= {instr[14:0], spi_sdio_i};
                end else begin
                    wshift <= {wshift[5:0], spi_sdio_i};
                end
            end
        end
    end

    // read data changes on the falling edge so the host samples it on the rising one
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            spi_sdio_o      <= 1'b0;
            spi_sdio_oe_n_o <= 1'b1;
        end else if (ce_i) begin
            if (spi_csb_n_i || bit_cnt == `DCFG_SPI_END) begin
                spi_sdio_oe_n_o <= 1'b1;
            end else if (sclk_fall && in_data && is_read) begin
                spi_sdio_oe_n_o <= 1'b0;
                spi_sdio_o      <= rd_val[~bit_cnt[2:0]];
            end
        end
    end

    // configuration registers, masked so open bits never store
    wire       ovr_upgrade = ovr_act.en && ((ovr_act.rate > `DCFG_RATE_DEFAULT)
                           || (ovr_act.res < `DCFG_RES_14));
    wire       sync_hit    = sync_i && sync_ctl[`DCFG_B_SYNC_EN];
    wire [1:0] sel         = chan_idx[1:0];

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            chan_idx  <= `DCFG_R_CHAN_IDX;
            pwr_mode  <= `DCFG_R_ZERO;
            enh       <= `DCFG_R_ZERO;
            ovr_stage <= `DCFG_R_ZERO;
            uio2      <= `DCFG_R_ZERO;
            uio3      <= `DCFG_R_ZERO;
        end else if (ce_i) begin
            if (wr_chan) begin
                chan_idx <= wr_data & `DCFG_M_CHAN_IDX;
            end
            if (wr_pwr) begin
                pwr_mode <= wr_data & `DCFG_M_PWR;
            end
            if (wr_enh) begin
                enh <= wr_data & `DCFG_M_ENH;
            end
            if (wr_ovr) begin
                ovr_stage <= wr_data & `DCFG_M_OVR;
            end
            if (wr_uio2) begin
                uio2 <= wr_data & `DCFG_M_UIO2;
            end
            if (wr_uio3) begin
                uio3 <= wr_data & `DCFG_M_UIO3;
            end
        end
    end

    // per-channel bits only touch the channels selected at the time of the write
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            out_mode <= `DCFG_R_ZERO;
            port_dis <= 2'h0;
            port_inv <= 2'h0;
        end else if (ce_i && wr_outm) begin
            out_mode <= wr_data & `DCFG_M_OUTM;
            for (int c = 0; c < 2; c++) begin
                if (sel[c]) begin
                    port_dis[c] <= wr_data[`DCFG_B_PORT_DIS];
                    port_inv[c] <= wr_data[`DCFG_B_INV];
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync_ctl <= `DCFG_R_ZERO;
        end else if (ce_i) begin
            // a host write in the same cycle overrides the one-shot clear
            if (wr_sync) begin
                sync_ctl <= wr_data & `DCFG_M_SYNC;
            end else if (sync_hit && sync_ctl[`DCFG_B_SYNC_NEXT]) begin
                sync_ctl[`DCFG_B_SYNC_EN] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ovr_act <= '0;
        end else if (ce_i) begin
            // only the transfer strobe moves the staged copy into service
            if (wr_xfer && wr_data[`DCFG_B_XFER]) begin
                ovr_act <= ovr_stage[6:0];
            end
        end
    end

    // power state
    wire [1:0] imode  = pwr_mode[1:0];
    wire       pin_pd = power_down_pin_i && pwr_mode[`DCFG_B_PIN_FULL];
    wire       pin_sb = power_down_pin_i && !pwr_mode[`DCFG_B_PIN_FULL];

    always_comb begin
        if (pin_pd || ovr_upgrade || imode == 2'h1) begin
            next_pwr_state = PS_DOWN;
        end else if (pin_sb || imode == 2'h2) begin
            next_pwr_state = PS_STBY;
        end else if (imode == 2'h3) begin
            next_pwr_state = PS_DRST;
        end else begin
            next_pwr_state = PS_RUN;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pwr_state <= PS_RUN;
        end else if (ce_i) begin
            pwr_state <= next_pwr_state;
        end
    end

    logic dp_run;
    logic dp_rst;
    logic outs_on;
    always_comb begin
        case (pwr_state)
            PS_RUN: begin
                dp_run  = 1'b1;
                dp_rst  = 1'b0;
                outs_on = 1'b1;
            end
            PS_STBY: begin
                dp_run  = 1'b0;
                dp_rst  = 1'b0;
                outs_on = 1'b0;
            end
            PS_DOWN: begin
                dp_run  = 1'b0;
                dp_rst  = 1'b1;
                outs_on = 1'b0;
            end
            PS_DRST: begin
                dp_run  = 1'b0;
                dp_rst  = 1'b1;
                outs_on = 1'b1;
            end
            default: begin
                dp_run  = 1'b0;
                dp_rst  = 1'b1;
                outs_on = 1'b0;
            end
        endcase
    end

    // output path: one sample pair per two system clocks, data clock at half rate
    wire        lvds    = out_mode[`DCFG_B_LVDS];
    wire        ilv     = out_mode[`DCFG_B_ILV];
    wire        hi      = ~phase;
    wire [13:0] mask    = res_mask(ovr_act);
    wire [13:0] pa_fmt  = fmt(cap.a, out_mode[1:0]) & mask;
    wire [13:0] pb_fmt  = fmt(cap.b, out_mode[1:0]) & mask;
    wire [13:0] pa      = port_inv[0] ? ~pa_fmt : pa_fmt;
    wire [13:0] pb      = port_inv[1] ? ~pb_fmt : pb_fmt;
    wire [13:0] lv_word = ilv ? (hi ? pa : pb) : pick({pb, pa}, ~hi);
    wire [13:0] cm_a    = (ilv && hi) ? pb : pa;
    wire [13:0] cm_b    = (ilv && hi) ? pa : pb;
    wire [13:0] next_a  = lvds ? lv_word : cm_a;
    wire [13:0] next_b  = lvds ? 14'h0 : cm_b;
    // the pin only counts once software has armed it
    wire        oeb_off = uio2[`DCFG_B_OEB_EN] && output_enable_pin_n_i;
    wire        on_all  = outs_on && !oeb_off;
    wire        next_en_a = on_all && (lvds ? !(&port_dis) : !port_dis[0]);
    wire        next_en_b = on_all && !lvds && !port_dis[1];

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cap              <= '0;
            phase            <= 1'b0;
            port_a_o         <= 14'h0;
            port_b_o         <= 14'h0;
            data_clock_out_o <= 1'b0;
        end else if (ce_i) begin
            if (dp_rst) begin
                cap      <= '0;
                phase    <= 1'b0;
                port_a_o <= 14'h0;
                port_b_o <= 14'h0;
                data_clock_out_o <= 1'b0;
            end else if (dp_run) begin
                // a stopped clock without datapath reset (standby) freezes the last word on the port
                phase <= hi;
                data_clock_out_o <= hi;
                if (!phase) begin
                    cap <= '{a: adc_a_i, b: adc_b_i};
                end
                port_a_o <= next_a;
                port_b_o <= next_b;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            port_a_en_o              <= 1'b0;
            port_b_en_o              <= 1'b0;
            lvds_en_o                <= 1'b0;
            lvds_reduced_o           <= 1'b0;
        end else if (ce_i) begin
            port_a_en_o              <= next_en_a;
            port_b_en_o              <= next_en_b;
            lvds_en_o                <= lvds;
            lvds_reduced_o           <= lvds && out_mode[`DCFG_B_LVDS_RED];
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            chop_en_o                <= 1'b0;
            common_mode_voltage_pd_o <= 1'b0;
            sdio_pull_dis_o          <= 1'b0;
        end else if (ce_i) begin
            chop_en_o                <= enh[`DCFG_B_CHOP];
            common_mode_voltage_pd_o <= uio3[`DCFG_B_CM_PD];
            sdio_pull_dis_o          <= uio2[`DCFG_B_PULL_DIS];
        end
    end

    // status flags trail their sources by one clock: power state, sync gate and override
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            divider_resync_o         <= 1'b0;
            full_power_down_o        <= 1'b0;
            standby_o                <= 1'b0;
            ovr_active_o             <= 7'h0;
        end else if (ce_i) begin
            divider_resync_o         <= sync_hit;
            full_power_down_o        <= pwr_state == PS_DOWN;
            standby_o                <= pwr_state == PS_STBY;
            ovr_active_o             <= ovr_act;
        end
    end
endmodule
`default_nettype wire

// File: test/dcfg_host.sv
`timescale 1ns/1ps
`default_nettype none
module dcfg_host (
    input  wire logic clk_sys_i,
    input  wire logic sdio_i,
    output var  logic csb_n_o,
    output var  logic sclk_o,
    output var  logic sdio_o,
    output var  logic sdio_drv_o
);
    // sclk idles low between frames; 3 clk halves leave margin for edge detect
    initial begin
        csb_n_o = 1'b1;
        sclk_o = 1'b0;
        sdio_o = 1'b0;
        sdio_drv_o = 1'b0;
    end
    task automatic xfer(input logic rd, input logic [12:0] adr, input logic [7:0] wd,
                        output logic [7:0] rdat);
        logic [23:0] fr;
        fr = {rd, 2'b00, adr, wd};
        rdat = 8'h00;
        @(posedge clk_sys_i);
        csb_n_o <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sdio_drv_o <= !(rd && i < 8);
            sdio_o <= fr[i];
            repeat (3) @(posedge clk_sys_i);
            if (i < 8) rdat[i] = sdio_i;
            sclk_o <= 1'b1;
            repeat (3) @(posedge clk_sys_i);
            sclk_o <= 1'b0;
        end
        sdio_drv_o <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        csb_n_o <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
    endtask
endmodule
`default_nettype wire

// File: test/dcfg_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dcfg_top_chk (
    input wire logic        clk_sys_i,
    input wire logic        sys_rst_i,
    input wire logic        power_down_pin_i,
    input wire logic        sync_i,
    input wire logic [13:0] port_b_o,
    input wire logic        data_clock_out_o,
    input wire logic        port_a_en_o,
    input wire logic        port_b_en_o,
    input wire logic        lvds_en_o,
    input wire logic        lvds_reduced_o,
    input wire logic        divider_resync_o,
    input wire logic        full_power_down_o,
    input wire logic        standby_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    chk_reduced_needs_lvds: assert property (lvds_reduced_o |-> lvds_en_o)
        else $error("reduced swing without lvds");
    chk_resync_has_cause: assert property (divider_resync_o |-> $past(sync_i))
        else $error("resync without sync pulse");
    chk_lvds_port_b: assert property (
        lvds_en_o && $past(lvds_en_o) |-> !port_b_en_o && port_b_o == 14'h0000)
        else $error("port b active in lvds");
    chk_stby_ports_off: assert property (
        standby_o && $past(standby_o) |-> !port_a_en_o && !port_b_en_o)
        else $error("ports on in standby");
    chk_down_ports_off: assert property (
        full_power_down_o && $past(full_power_down_o) |-> !port_a_en_o && !port_b_en_o)
        else $error("ports on in power down");
    chk_stby_clock_held: assert property (standby_o [*3] |-> $stable(data_clock_out_o))
        else $error("data clock runs in standby");
    chk_down_clock_held: assert property (
        full_power_down_o [*3] |-> $stable(data_clock_out_o))
        else $error("data clock runs in power down");
    chk_pin_power_mode: assert property (
        power_down_pin_i [*3] |-> full_power_down_o || standby_o)
        else $error("power-down pin ignored");
    cov_standby: cover property (standby_o);
    cov_down: cover property (full_power_down_o);
    cov_resync: cover property (divider_resync_o);
endmodule
bind dcfg_top dcfg_top_chk u_chk (.clk_sys_i, .sys_rst_i, .power_down_pin_i, .sync_i,
    .port_b_o, .data_clock_out_o, .port_a_en_o, .port_b_en_o, .lvds_en_o, .lvds_reduced_o,
    .divider_resync_o, .full_power_down_o, .standby_o);
`default_nettype wire

// File: test/dcfg_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcfg_consts.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module dcfg_top_test;
    logic        clk_sys_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        pd_pin = 1'b0;
    logic        oe_pin_n = 1'b0;
    logic        sync = 1'b0;
    logic [13:0] adc_a = 14'h0000;
    logic [13:0] adc_b = 14'h0000;
    logic        tgl = 1'b0;
    logic        csb_n, sclk, h_sdio, h_drv, sdio_w, d_sdio, d_oe_n, dclk, a_en, b_en;
    logic        lvds, lvds_red, chop, cm_pd, pull_dis, resync, full_pd, stby;
    logic [13:0] port_a, port_b;
    logic [6:0]  ovr;
    logic [7:0]  regm [8];
    logic [7:0]  wd;
    bit          da, db, ia, ib;
    int          miscompares = 0;
    int          checked = 0;
    int          seed = 32'h3de5b52b;
    logic [12:0] adr [8] = '{13'h5, 13'h8, 13'hc, 13'h14, 13'h3a, 13'h100, 13'h101, 13'h102};
    logic [7:0]  msk [8] = '{8'h03, 8'h23, 8'h04, 8'hf7, 8'h06, 8'h7f, 8'h81, 8'h08};
    logic [13:0] rmask = 14'h3fff;
    logic [15:0] tbl [11] = '{16'h0300, 16'h0301, 16'h0302, 16'h0320, 16'h0380, 16'h03a0,
                              16'h03c0, 16'h0304, 16'h0110, 16'h0224, 16'h0300};
    always #5 clk_sys_i = ~clk_sys_i;
    // released sdio: pull-down, or a toggling level once the pull-down is off
    always @(posedge clk_sys_i) tgl <= ~tgl;
    assign sdio_w = !d_oe_n ? d_sdio : h_drv ? h_sdio : pull_dis & tgl;
    dcfg_host u_host (.clk_sys_i(clk_sys_i), .sdio_i(sdio_w), .csb_n_o(csb_n),
        .sclk_o(sclk), .sdio_o(h_sdio), .sdio_drv_o(h_drv));
    dcfg_top u_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
        .spi_csb_n_i(csb_n), .spi_sclk_i(sclk), .spi_sdio_i(sdio_w), .spi_sdio_o(d_sdio),
        .spi_sdio_oe_n_o(d_oe_n), .power_down_pin_i(pd_pin), .output_enable_pin_n_i(oe_pin_n),
        .sync_i(sync), .adc_a_i(adc_a), .adc_b_i(adc_b), .port_a_o(port_a), .port_b_o(port_b),
        .data_clock_out_o(dclk), .port_a_en_o(a_en), .port_b_en_o(b_en), .lvds_en_o(lvds),
        .lvds_reduced_o(lvds_red), .chop_en_o(chop), .common_mode_voltage_pd_o(cm_pd),
        .sdio_pull_dis_o(pull_dis), .divider_resync_o(resync), .full_power_down_o(full_pd),
        .standby_o(stby), .ovr_active_o(ovr));
    task automatic final_report;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] r;
        u_host.xfer(1'b0, a, d, r);
    endtask
    task automatic rdc(input logic [12:0] a, input logic [7:0] e);
        logic [7:0] r;
        u_host.xfer(1'b1, a, 8'h00, r);
        `CHK(r, e)
    endtask
    task automatic tick;
        repeat (4) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask
    task automatic pulse(input logic e);
        @(posedge clk_sys_i);
        sync <= 1'b1;
        @(posedge clk_sys_i);
        sync <= 1'b0;
        @(negedge clk_sys_i);
        `CHK(resync, e)
    endtask
    function automatic logic [13:0] chan(logic [13:0] s, logic [1:0] f, bit inv);
        logic [13:0] c;
        c = ((f == 2'h1) ? s ^ 14'h2000 : (f == 2'h2) ? s ^ (s >> 1) : s) & rmask;
        return inv ? ~c : c;
    endfunction
    task automatic dp(input logic [7:0] ci, input logic [7:0] om);
        logic [13:0] ea, eb, xa, xb;
        logic [1:0]  en;
        bit          d0;
        wr(`DCFG_A_CHAN_IDX, ci);
        adc_a <= 14'($random(seed));
        adc_b <= 14'($random(seed));
        wr(`DCFG_A_OUTM, om);
        if (ci[0]) begin da = om[4]; ia = om[2]; end
        if (ci[1]) begin db = om[4]; ib = om[2]; end
        xa = chan(adc_a, om[1:0], ia);
        xb = chan(adc_b, om[1:0], ib);
        en = om[7] ? {!(da && db), 1'b0} : {!da, !db};
        repeat (4) @(posedge clk_sys_i);
        for (int n = 0; n < 2; n++) begin
            @(negedge clk_sys_i);
            for (int k = 0; k < 14; k++) ea[k] = dclk ? (k < 7 ? xa[2*k] : xb[2*k-14])
                                                     : (k < 7 ? xa[2*k+1] : xb[2*k-13]);
            eb = 14'h0000;
            if (!om[7]) ea = (om[5] && dclk) ? xb : xa;
            if (!om[7]) eb = (om[5] && dclk) ? xa : xb;
            if (om[7] && om[5]) ea = dclk ? xa : xb;
            if (en[1]) `CHK(port_a, ea)
            if (en[0] || om[7]) `CHK(port_b, eb)
            `CHK({a_en, b_en}, en)
            `CHK({lvds, lvds_red}, {om[7], om[7] & om[6]})
            if (n) `CHK(dclk, !d0)
            d0 = dclk;
        end
    endtask
    initial begin
        repeat (4) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        for (int i = 0; i < 8; i++) rdc(adr[i], i ? 8'h00 : 8'h03);
        rdc(13'h0ab, 8'h00);
        rdc(`DCFG_A_XFER, 8'h00);
        for (int i = 1; i < 8; i++) begin
            wd = 8'($random(seed));
            regm[i] = wd & msk[i];
            wr(adr[i], wd);
        end
        for (int i = 1; i < 8; i++) rdc(adr[i], regm[i]);
        `CHK({chop, cm_pd, pull_dis}, {regm[2][2], regm[7][3], regm[6][0]})
        for (int i = 1; i < 8; i++) wr(adr[i], 8'h00);
        // both channels stay selected here before the reset mode
        for (int i = 0; i < 4; i++) begin
            wr(`DCFG_A_PWR, 8'(i));
            tick();
            `CHK({full_pd, stby, a_en}, {i == 1, i == 2, i == 0 || i == 3})
        end
        wr(`DCFG_A_PWR, 8'h20);
        pd_pin <= 1'b1;
        tick();
        `CHK({full_pd, stby}, 2'b10)
        wr(`DCFG_A_PWR, 8'h00);
        tick();
        `CHK({full_pd, stby}, 2'b01)
        @(posedge clk_sys_i);
        pd_pin <= 1'b0;
        wr(`DCFG_A_UIO2, 8'h80);
        oe_pin_n <= 1'b1;
        tick();
        `CHK({a_en, b_en}, 2'b00)
        wr(`DCFG_A_UIO2, 8'h00);
        tick();
        `CHK({a_en, b_en}, 2'b11)
        @(posedge clk_sys_i);
        oe_pin_n <= 1'b0;
        wr(`DCFG_A_OVR, 8'h53);
        tick();
        `CHK(ovr, 7'h00)
        wr(`DCFG_A_XFER, 8'h01);
        tick();
        `CHK({full_pd, ovr}, {1'b0, 7'h53})
        wr(`DCFG_A_OVR, 8'h56);
        wr(`DCFG_A_XFER, 8'h01);
        tick();
        `CHK(full_pd, 1'b1)
        wr(`DCFG_A_OVR, 8'h00);
        wr(`DCFG_A_XFER, 8'h01);
        tick();
        `CHK(full_pd, 1'b0)
        wr(`DCFG_A_SYNC, 8'h02);
        pulse(1'b1);
        pulse(1'b1);
        wr(`DCFG_A_SYNC, 8'h06);
        pulse(1'b1);
        rdc(`DCFG_A_SYNC, 8'h04);
        pulse(1'b0);
        for (int i = 0; i < 11; i++) dp(tbl[i][15:8], tbl[i][7:0]);
        wr(`DCFG_A_OVR, 8'h63);
        wr(`DCFG_A_XFER, 8'h01);
        rmask = `DCFG_MASK_12;
        dp(8'h03, 8'h01);
        wr(`DCFG_A_OVR, 8'h73);
        wr(`DCFG_A_XFER, 8'h01);
        rmask = `DCFG_MASK_10;
        dp(8'h03, 8'h80);
        final_report();
    end
    initial begin
        #400000;
        miscompares++;
        final_report();
    end
endmodule
`default_nettype wire
